// >>> inc/fan_consts.svh
`ifndef FAN_CONSTS_SVH
`define FAN_CONSTS_SVH

// Core clock rate.
`define FAN_CLK_MHZ        10

// Restart cycle times in milliseconds.
`define FAN_TON_MS         560
`define FAN_TOFF_MS        6800
// Lock detection is one and a half on intervals.
`define FAN_TLOCK_NUM      3
`define FAN_TLOCK_DEN      2
`define FAN_TON_CYC        (`FAN_TON_MS * `FAN_CLK_MHZ * 1000)
`define FAN_TOFF_CYC       (`FAN_TOFF_MS * `FAN_CLK_MHZ * 1000)
`define FAN_TLOCK_CYC      (`FAN_TON_CYC * `FAN_TLOCK_NUM / `FAN_TLOCK_DEN)

// Commutation delay in microseconds and cycles.
`define FAN_CDLY_US        100
`define FAN_CDLY_CYC       (`FAN_CDLY_US * `FAN_CLK_MHZ)

// Counter and data widths.
`define FAN_LOCK_W         27
`define FAN_CDLY_W         12
`define FAN_CMD_W          8
`define FAN_DUTY_W         8
`define FAN_PWM_CNT_W      7

// Speed command codes, one LSB is 1/64 V.
`define FAN_CMD_ZERO_DRIVE 8'hc0
`define FAN_CMD_FULL_DRIVE 8'h40
`define FAN_DUTY_FULL      8'h80
`define FAN_CORR_MAX       8'hff

`endif

// >>> inc/fan_pkg.sv
`include "fan_consts.svh"

package fan_pkg;

  typedef enum logic [1:0] {
    LOCK_RUN = 2'b00,
    LOCK_OFF = 2'b01,
    LOCK_ON  = 2'b11
  } lock_state_e;

  typedef struct packed {
    logic [`FAN_PWM_CNT_W-1:0] cnt;
    logic                      pwm;
    logic                      tick;
  } pwm_state_s;

  typedef struct packed {
    logic [1:0]              hall_meta;
    logic [1:0]              hall_sync;
    logic [`FAN_CMD_W-1:0]   cmd_meta;
    logic [`FAN_CMD_W-1:0]   cmd_sync;
    logic [`FAN_CMD_W-1:0]   cmd_hold;
    logic [`FAN_CMD_W-1:0]   cmd_q;
    logic [`FAN_CMD_W-1:0]   min_meta;
    logic [`FAN_CMD_W-1:0]   min_sync;
    logic [`FAN_CMD_W-1:0]   min_hold;
    logic [`FAN_CMD_W-1:0]   min_q;
    logic [`FAN_CMD_W-1:0]   thr_meta;
    logic [`FAN_CMD_W-1:0]   thr_sync;
    logic [`FAN_CMD_W-1:0]   thr_hold;
    logic [`FAN_CMD_W-1:0]   thr_q;
    logic [`FAN_CMD_W-1:0]   sense_meta;
    logic [`FAN_CMD_W-1:0]   sense_sync;
    logic [`FAN_CMD_W-1:0]   sense_hold;
    logic [`FAN_CMD_W-1:0]   sense_q;
    logic                    hall_prev;
    logic                    phase_b;
    logic                    cdly_busy;
    logic [`FAN_CDLY_W-1:0]  cdly_cnt;
    lock_state_e             lock_st;
    logic [`FAN_LOCK_W-1:0]  lock_cnt;
    logic [`FAN_CMD_W-1:0]   corr;
    logic [`FAN_DUTY_W-1:0]  duty;
    logic                    hs_a;
    logic                    hs_b;
    logic                    ls_a;
    logic                    ls_b;
    logic                    stall;
    logic                    speed;
  } fan_state_s;

endpackage

// >>> design/fan_pwm_gen.sv
`include "fan_consts.svh"

module fan_pwm_gen
  import fan_pkg::*;
(
  // Clock and reset.
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst_n,
  // Duty request, 0 to full scale.
  input  wire logic [`FAN_DUTY_W-1:0] i_duty,
  // Chopping waveform and period start.
  output logic                        o_pwm,
  output logic                        o_period_tick
);

  pwm_state_s s_r;
  pwm_state_s s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.cnt  = s_r.cnt + `FAN_PWM_CNT_W'(1);
    s_nxt.tick = (s_r.cnt == '1);
    // Duty is one bit wider than the counter so that full scale means always on.
    s_nxt.pwm  = ({1'b0, s_r.cnt} < i_duty);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_pwm         = s_r.pwm;
  assign o_period_tick = s_r.tick;

endmodule

// >>> design/fan_lock_restart_drive.sv
// Overview of operation
// - Stopped rotor: after lock time, flag, drive off.
// - Locked: off wait, on attempt, repeat forever.
// - On to off ratio 1:12, 0.56s/6.8s.
// - Lock detection lasts 1.5 on intervals.
// - Stall flag high stopped, low running.
// - Speed pulse copies the Hall level.
// - Low side carries commutation and PWM.
// - High side follows commutation, never PWM.
// - Inactive phase low side held low.
// - Over-current adds correction to speed command.
// - Below threshold, speed command left unchanged.
// - Minimum speed overrides the current limiter.
// - Command 3V is 0%, 1V is 100%.
// - Command clamped to the minimum speed setting.
// - Phase b active while Hall positive above negative.
// - Commutation waits 100us after each Hall edge.
`include "fan_consts.svh"

module fan_lock_restart_drive
  import fan_pkg::*;
#(
  parameter int unsigned TON_CYC   = `FAN_TON_CYC,
  parameter int unsigned TOFF_CYC  = `FAN_TOFF_CYC,
  parameter int unsigned TLOCK_CYC = `FAN_TLOCK_CYC,
  parameter int unsigned CDLY_CYC  = `FAN_CDLY_CYC
) (
  // Clock and reset.
  input  wire logic                  i_core_clk,
  input  wire logic                  i_resetn,
  // Hall comparator levels.
  input  wire logic                  i_hall_pos,
  input  wire logic                  i_hall_neg,
  // Speed, minimum speed and current limit codes.
  input  wire logic [`FAN_CMD_W-1:0] i_speed_command,
  input  wire logic [`FAN_CMD_W-1:0] i_minimum_speed_limit,
  input  wire logic [`FAN_CMD_W-1:0] i_current_threshold,
  input  wire logic [`FAN_CMD_W-1:0] i_current_sense,
  // Bridge drive.
  output logic                       o_high_side_drive_a,
  output logic                       o_high_side_drive_b,
  output logic                       o_low_side_drive_a,
  output logic                       o_low_side_drive_b,
  // Status flags.
  output logic                       o_stall_flag,
  output logic                       o_speed_pulse
);

  logic [1:0]             rst_sync_r;
  logic                   rst_n;
  fan_state_s             s_r;
  fan_state_s             s_nxt;
  logic                   pwm;
  logic                   period_tick;
  logic                   hall_lvl;
  logic                   hall_edge;
  logic                   drive_en;
  logic [`FAN_CMD_W-1:0]  base_cmd;
  logic [`FAN_CMD_W:0]    sum_cmd;
  logic [`FAN_CMD_W-1:0]  eff_cmd;
  logic [`FAN_DUTY_W-1:0] duty_calc;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];

  fan_pwm_gen u_pwm (
    .i_core_clk    (i_core_clk),
    .i_rst_n       (rst_n),
    .i_duty        (s_r.duty),
    .o_pwm         (pwm),
    .o_period_tick (period_tick)
  );

  always_comb begin
    s_nxt = s_r;

    // Every pin input passes two flip-flops before use.
    s_nxt.hall_meta  = {i_hall_pos, i_hall_neg};
    s_nxt.hall_sync  = s_r.hall_meta;
    s_nxt.cmd_meta   = i_speed_command;
    s_nxt.cmd_sync   = s_r.cmd_meta;
    s_nxt.min_meta   = i_minimum_speed_limit;
    s_nxt.min_sync   = s_r.min_meta;
    s_nxt.thr_meta   = i_current_threshold;
    s_nxt.thr_sync   = s_r.thr_meta;
    s_nxt.sense_meta = i_current_sense;
    s_nxt.sense_sync = s_r.sense_meta;

    // Bits of a code may settle a cycle apart, so a code is taken only when
    // two synchronised samples agree. A code that never rests is never taken.
    s_nxt.cmd_hold   = s_r.cmd_sync;
    s_nxt.min_hold   = s_r.min_sync;
    s_nxt.thr_hold   = s_r.thr_sync;
    s_nxt.sense_hold = s_r.sense_sync;
    if (s_r.cmd_sync == s_r.cmd_hold) begin
      s_nxt.cmd_q = s_r.cmd_sync;
    end
    if (s_r.min_sync == s_r.min_hold) begin
      s_nxt.min_q = s_r.min_sync;
    end
    if (s_r.thr_sync == s_r.thr_hold) begin
      s_nxt.thr_q = s_r.thr_sync;
    end
    if (s_r.sense_sync == s_r.sense_hold) begin
      s_nxt.sense_q = s_r.sense_sync;
    end

    hall_lvl  = s_r.hall_sync[1] & ~s_r.hall_sync[0];
    hall_edge = (hall_lvl != s_r.hall_prev);
    s_nxt.hall_prev = hall_lvl;

    // A new edge restarts the delay, so Hall bounce never commutes early.
    if (hall_edge) begin
      s_nxt.cdly_busy = 1'b1;
      s_nxt.cdly_cnt  = '0;
    end else if (s_r.cdly_busy) begin
      if (s_r.cdly_cnt >= `FAN_CDLY_W'(CDLY_CYC - 1)) begin
        s_nxt.phase_b   = hall_lvl;
        s_nxt.cdly_busy = 1'b0;
      end else begin
        s_nxt.cdly_cnt = s_r.cdly_cnt + `FAN_CDLY_W'(1);
      end
    end

    // Lock supervisor.
    case (s_r.lock_st)
      LOCK_RUN: begin
        if (hall_edge) begin
          s_nxt.lock_cnt = '0;
        end else if (s_r.lock_cnt >= `FAN_LOCK_W'(TLOCK_CYC - 1)) begin
          s_nxt.lock_st  = LOCK_OFF;
          s_nxt.lock_cnt = '0;
        end else begin
          s_nxt.lock_cnt = s_r.lock_cnt + `FAN_LOCK_W'(1);
        end
      end
      LOCK_OFF: begin
        if (s_r.lock_cnt >= `FAN_LOCK_W'(TOFF_CYC - 1)) begin
          s_nxt.lock_st  = LOCK_ON;
          s_nxt.lock_cnt = '0;
        end else begin
          s_nxt.lock_cnt = s_r.lock_cnt + `FAN_LOCK_W'(1);
        end
      end
      LOCK_ON: begin
        if (hall_edge) begin
          s_nxt.lock_st  = LOCK_RUN;
          s_nxt.lock_cnt = '0;
        end else if (s_r.lock_cnt >= `FAN_LOCK_W'(TON_CYC - 1)) begin
          s_nxt.lock_st  = LOCK_OFF;
          s_nxt.lock_cnt = '0;
        end else begin
          s_nxt.lock_cnt = s_r.lock_cnt + `FAN_LOCK_W'(1);
        end
      end
      default: begin
        s_nxt.lock_st  = LOCK_RUN;
        s_nxt.lock_cnt = '0;
      end
    endcase

    // Current limiter, stepped once per PWM period to keep the loop slow.
    // Dropping the correction at once when below threshold may cause
    // ripple around the limit; that was traded for an unchanged command.
    if (period_tick) begin
      if (s_r.sense_q > s_r.thr_q) begin
        if (s_r.corr != `FAN_CORR_MAX) begin
          s_nxt.corr = s_r.corr + `FAN_CMD_W'(1);
        end
      end else begin
        s_nxt.corr = '0;
      end
    end

    if (s_r.cmd_q > s_r.min_q) begin
      base_cmd = s_r.min_q;
    end else begin
      base_cmd = s_r.cmd_q;
    end
    sum_cmd = {1'b0, base_cmd} + {1'b0, s_r.corr};
    if (sum_cmd > {1'b0, s_r.min_q}) begin
      eff_cmd = s_r.min_q;
    end else begin
      eff_cmd = sum_cmd[`FAN_CMD_W-1:0];
    end

    if (eff_cmd >= `FAN_CMD_ZERO_DRIVE) begin
      duty_calc = '0;
    end else if (eff_cmd <= `FAN_CMD_FULL_DRIVE) begin
      duty_calc = `FAN_DUTY_FULL;
    end else begin
      duty_calc = `FAN_CMD_ZERO_DRIVE - eff_cmd;
    end
    s_nxt.duty = duty_calc;

    // Registered outputs.
    // Drive follows the next lock state so it drops in the cycle the flag rises.
    drive_en    = (s_nxt.lock_st != LOCK_OFF);
    s_nxt.hs_a  = drive_en & ~s_r.phase_b;
    s_nxt.hs_b  = drive_en & s_r.phase_b;
    s_nxt.ls_a  = drive_en & ~s_r.phase_b & pwm;
    s_nxt.ls_b  = drive_en & s_r.phase_b & pwm;
    s_nxt.stall = (s_nxt.lock_st != LOCK_RUN);
    s_nxt.speed = hall_lvl;
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_high_side_drive_a = s_r.hs_a;
  assign o_high_side_drive_b = s_r.hs_b;
  assign o_low_side_drive_a  = s_r.ls_a;
  assign o_low_side_drive_b  = s_r.ls_b;
  assign o_stall_flag        = s_r.stall;
  assign o_speed_pulse       = s_r.speed;

endmodule

// >>> test/fan_hall_model.sv
module fan_hall_model (
  // Clock and rotation control.
  input  wire logic       i_clk,
  input  wire logic       i_run,
  input  wire logic [7:0] i_half,
  // Hall comparator pair.
  output logic            o_hall_pos,
  output logic            o_hall_neg
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt;
  initial begin
    cnt = 8'h00;
    o_hall_pos = 1'b0;
    o_hall_neg = 1'b1;
  end
  // A stopped rotor holds its last Hall level, as a real magnet would.
  always @(negedge i_clk) begin
    if (!i_run) begin
      cnt <= 8'h00;
    end else if (cnt + 8'h01 >= i_half) begin
      cnt <= 8'h00;
      o_hall_pos <= ~o_hall_pos;
      o_hall_neg <= o_hall_pos;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule

// >>> test/fan_lock_restart_drive_asserts.sv
`include "fan_consts.svh"

module fan_lock_restart_drive_asserts #(
  parameter int unsigned TON_CYC   = 20,
  parameter int unsigned TOFF_CYC  = 240,
  parameter int unsigned TLOCK_CYC = 30,
  parameter int unsigned CDLY_CYC  = 8
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_hall_pos,
  input wire logic i_hall_neg,
  input wire logic o_high_side_drive_a,
  input wire logic o_high_side_drive_b,
  input wire logic o_low_side_drive_a,
  input wire logic o_low_side_drive_b,
  input wire logic o_stall_flag,
  input wire logic o_speed_pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0]  up_r;
  logic        sp_r;
  logic [15:0] qc_r;
  wire         hh = i_hall_pos & ~i_hall_neg;
  wire         any = o_high_side_drive_a | o_high_side_drive_b | o_low_side_drive_a | o_low_side_drive_b;
  // Checks wait out the reset synchroniser, where outputs are forced low.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      up_r <= 4'h0;
      sp_r <= 1'b0;
      qc_r <= 16'h0000;
    end else begin
      up_r <= (up_r == 4'hf) ? up_r : up_r + 4'h1;
      sp_r <= o_speed_pulse;
      qc_r <= (o_speed_pulse != sp_r) ? 16'h0000 : qc_r + 16'h0001;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn || up_r != 4'hf);
  sequence s_hi; hh [*5]; endsequence
  sequence s_lo; !hh [*5]; endsequence
  sequence s_dark; !any [*8]; endsequence
  property p_spd_hi; s_hi |-> o_speed_pulse; endproperty
  property p_spd_lo; s_lo |-> !o_speed_pulse; endproperty
  property p_ls_a; o_low_side_drive_a |-> o_high_side_drive_a; endproperty
  property p_ls_b; o_low_side_drive_b |-> o_high_side_drive_b; endproperty
  property p_hs_ex; !(o_high_side_drive_a && o_high_side_drive_b); endproperty
  property p_off; $rose(o_stall_flag) |-> s_dark; endproperty
  property p_tlock; $rose(o_stall_flag) |-> qc_r inside {[TLOCK_CYC-3:TLOCK_CYC+3]}; endproperty
  property p_cdly; $rose(o_high_side_drive_b) && !o_stall_flag |-> qc_r inside {[CDLY_CYC-3:CDLY_CYC+2]}; endproperty
  property p_rel; $fell(o_stall_flag) |-> (o_high_side_drive_a || o_high_side_drive_b) ##1 !o_stall_flag; endproperty
  a_spd_hi: assert property (p_spd_hi) else $error("speed pulse low with Hall high");
  a_spd_lo: assert property (p_spd_lo) else $error("speed pulse high with Hall low");
  a_ls_a: assert property (p_ls_a) else $error("low side a on outside its phase");
  a_ls_b: assert property (p_ls_b) else $error("low side b on outside its phase");
  a_hs_ex: assert property (p_hs_ex) else $error("both high sides on");
  a_off: assert property (p_off) else $error("drive on at lock entry");
  a_tlock: assert property (p_tlock) else $error("lock detect time wrong");
  a_cdly: assert property (p_cdly) else $error("commutation delay wrong");
  a_rel: assert property (p_rel) else $error("restart left drive off");
endmodule

bind fan_lock_restart_drive fan_lock_restart_drive_asserts #(
  .TON_CYC(TON_CYC), .TOFF_CYC(TOFF_CYC), .TLOCK_CYC(TLOCK_CYC), .CDLY_CYC(CDLY_CYC)
) u_chk (
  .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_hall_pos(i_hall_pos), .i_hall_neg(i_hall_neg),
  .o_high_side_drive_a(o_high_side_drive_a), .o_high_side_drive_b(o_high_side_drive_b),
  .o_low_side_drive_a(o_low_side_drive_a), .o_low_side_drive_b(o_low_side_drive_b),
  .o_stall_flag(o_stall_flag), .o_speed_pulse(o_speed_pulse)
);

// >>> test/fan_lock_restart_drive_test.sv
module fan_lock_restart_drive_test;
  timeunit 1ns;
  timeprecision 1ns;
  import fan_pkg::*;
  localparam int TON = 20;
  localparam int TOFF = 240;
  logic       clk, rstn, run;
  logic [7:0] half, cmd, min_cmd, thr, sense, d0, h0;
  wire        hp, hn, hsa, hsb, lsa, lsb, stall, speed_command;
  int         num_errors, n_tests, seed, n;
  logic [7:0] ct [6] = '{8'h40, 8'hc0, 8'hd0, 8'h90, 8'h20, 8'h00};
  logic [7:0] st [6] = '{8'hff, 8'hff, 8'hff, 8'h60, 8'h50, 8'hff};
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  fan_hall_model u_hall (.i_clk(clk), .i_run(run), .i_half(half), .o_hall_pos(hp), .o_hall_neg(hn));
  fan_lock_restart_drive #(.TON_CYC(TON), .TOFF_CYC(TOFF), .TLOCK_CYC(30), .CDLY_CYC(8)) dut (
    .i_core_clk(clk), .i_resetn(rstn), .i_hall_pos(hp), .i_hall_neg(hn),
    .i_speed_command(cmd), .i_minimum_speed_limit(min_cmd), .i_current_threshold(thr),
    .i_current_sense(sense), .o_high_side_drive_a(hsa), .o_high_side_drive_b(hsb),
    .o_low_side_drive_a(lsa), .o_low_side_drive_b(lsb), .o_stall_flag(stall), .o_speed_pulse(speed_command));
  function logic [7:0] duty_of(input logic [7:0] c, input logic [7:0] s);
    logic [7:0] e;
    e = (c < s) ? c : s;
    if (e >= 8'hc0) return 8'h00;
    if (e <= 8'h40) return 8'h80;
    return 8'hc0 - e;
  endfunction
  task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task final_report;
    $display("mismatches %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One full chopping period is counted, so the phase of the window does not matter.
  task meas(input int wait_cyc);
    repeat (wait_cyc) @(negedge clk);
    d0 = 8'h00;
    h0 = 8'h00;
    repeat (128) begin
      @(negedge clk);
      d0 = d0 + {7'h00, lsa | lsb};
      h0 = h0 + {7'h00, hsa | hsb};
    end
  endtask
  initial begin
    #(100 * 40000);
    num_errors++;
    final_report();
  end
  initial begin
    seed = 79645;
    num_errors = 0;
    n_tests = 0;
    {rstn, run, half, cmd, min_cmd, thr, sense} = {2'b00, 8'd16, 8'h40, 8'hff, 8'h10, 8'h00};
    repeat (20) @(negedge clk);
    check("drive in reset", {4'h0, hsa, hsb, lsa, lsb}, 8'h00);
    {rstn, run} = 2'b11;
    for (int i = 0; i < 10; i++) begin
      half = 8'd12 + 8'($unsigned($random(seed)) % 8);
      cmd = (i < 6) ? ct[i] : 8'h41 + 8'($unsigned($random(seed)) % 126);
      min_cmd = (i < 6) ? st[i] : 8'h41 + 8'($unsigned($random(seed)) % 190);
      meas(400);
      check("duty", d0, duty_of(cmd, min_cmd));
      check("high side steady", h0, 8'h80);
      check("stall running", {7'h00, stall}, 8'h00);
    end
    {cmd, min_cmd, sense} = {8'h40, 8'hff, 8'h20};
    meas(400);
    check("limited", {7'h00, d0 < 8'h80}, 8'h01);
    min_cmd = 8'h80;
    meas(9000);
    check("minimum wins", d0, 8'h40);
    sense = 8'h00;
    meas(400);
    check("limit released", d0, 8'h80);
    run = 1'b0;
    n = 0;
    while (!stall && n < 200) begin
      @(negedge clk);
      n++;
    end
    check("lock time", {7'h00, n >= 10 && n <= 36}, 8'h01);
    check("speed pulse", {7'h00, speed_command}, {7'h00, hp & ~hn});
    for (int k = 0; k < 2; k++) begin
      n = 0;
      while (stall && !(hsa | hsb) && n < 1000) begin
        @(negedge clk);
        n++;
      end
      check("off time", 8'(n), 8'(TOFF));
      check("active phase", {7'h00, hsb}, {7'h00, hp & ~hn});
      n = 0;
      while (k == 0 && stall && (hsa | hsb) && n < 1000) begin
        @(negedge clk);
        n++;
      end
      if (k == 0) check("on time", 8'(n), 8'(TON));
    end
    {run, half} = {1'b1, 8'd4};
    n = 0;
    while (stall && n < TON) begin
      @(negedge clk);
      n++;
    end
    check("restart", {6'h00, stall, hsa | hsb}, 8'h01);
    half = 8'd14;
    meas(200);
    check("running again", {7'h00, stall}, 8'h00);
    final_report();
  end
endmodule
